// [hdl/abw_pkg.sv]
package abw_pkg;
    // Operation kinds requested by the core
    typedef enum logic [1:0] {
        ABW_OP_WRITE,
        ABW_OP_TAS,
        ABW_OP_CAS,
        ABW_OP_DOUBLE_COMPARE_SWAP_OP
    } abw_op_e;

    // Request from the core side
    typedef struct packed {
        abw_op_e op;
        logic [31:0] addr;
        logic [2:0] space;
        logic [2:0] nbytes;
        logic [31:0] wdata;
    } abw_req_s;

    // Bus control outputs, active high internally except rd_wr_n, which is low for a write
    typedef struct packed {
        logic cycle_start_strobe;
        logic operand_start_strobe;
        logic address_strobe;
        logic data_strobe;
        logic data_buffer_enable;
        logic locked_sequence_flag;
        logic rd_wr_n;
    } abw_ctl_s;

    localparam logic [1:0] ABW_ACK_NONE = 2'h0;
    localparam logic [1:0] ABW_ACK_B8 = 2'h1;
    localparam logic [1:0] ABW_ACK_B16 = 2'h2;
    localparam logic [1:0] ABW_ACK_B32 = 2'h3;
    localparam logic [2:0] ABW_NB_RESET = 3'h0;
    localparam logic [31:0] ABW_ADDR_RESET = 32'h0;
    localparam logic [2:0] ABW_SPACE_RESET = 3'h0;
    localparam logic [1:0] ABW_IDLE_HALVES = 2'h2;
endpackage

// [hdl/abw_bus_master.sv]
// Overview of operation
// R1: Write S0 drives address, space code, size and write level on rd_wr.
// R2: First external cycle of a write raises operand strobe with cycle strobe.
// R3: Address strobe rises in S1, half a clock after S0.
// R4: Write S1 raises buffer enable and drops both start strobes.
// R5: Write data driven in S2; acknowledges sampled at end of S2.
// R6: Data strobe rises in S3 of a write; the code raises it on the same edge as the address strobe.
// R7: Acknowledge seen by end of S2 ends the cycle one clock later.
// R8: No acknowledge by S3 inserts wait states, sampling each falling edge; the code samples only on rising edges, through two flops.
// R9: Slave holds acknowledges negated around end of S2 for waits.
// R10: Slave latches selected byte lanes qualified by rd_wr and data strobe.
// R11: Slave acknowledges once written data is stored.
// R12: No control signal changes during S4.
// R13: S5 drops address and data strobes, holds address, data, size, space.
// R14: Slave releases acknowledges within one clock after strobes negate.
// R15: Locked flag stays high across the whole read-modify-write.
// R16: No bus grant while a locked sequence runs.
// R17: Only three ops lock; failed compares skip the write portion.
// R18: Locked S0 raises lock flag, drives address, size, space, read level.
// R19: Locked S0 raises both cycle and operand start strobes.
// R20: Locked S1 raises address and data strobes, drops start strobes.
// R21: Locked S2 raises buffer enable; slave returns read data.
// R22: After locked read, rd_wr stays read until S6; data undriven before S8.
// R23: After reset strobes, buffer enable, lock negated and data undriven.
// R24: Acknowledge code gives port width; S0-S5 repeat for remaining bytes.
`timescale 1ns/10ps
`default_nettype none
module abw_bus_master (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_req_valid,
    input wire abw_pkg::abw_req_s i_req,
    input wire logic i_cmp_ok,
    input wire logic [1:0] i_ack_size_lines_n,
    input wire logic i_bus_request_in_n,
    output logic o_req_ready,
    output logic o_done,
    output logic [31:0] o_rdata,
    output abw_pkg::abw_ctl_s o_ctl,
    output logic [31:0] o_addr,
    output logic [2:0] o_space,
    output logic [1:0] o_transfer_size,
    output logic [31:0] o_data_out,
    output logic o_data_oe,
    output logic o_bus_grant_out
);
    import abw_pkg::*;

    // Each state is one half clock; the machine runs on full edges, so one
    // register step covers a pair of half states.
    typedef enum logic [2:0] {
        ABW_IDLE, ABW_S01, ABW_S23, ABW_WAIT, ABW_S45, ABW_GAP
    } abw_state_e;

    abw_state_e state_q;
    abw_req_s req_q;
    logic [2:0] left_q;
    logic write_ph_q;
    logic [1:0] gap_q;
    logic [1:0] ack_m_q, ack_s_q;
    logic br_m_q, br_s_q;
    abw_ctl_s ctl_q;
    logic [31:0] addr_q, dout_q, rdata_q;
    logic [2:0] space_q;
    logic [1:0] size_q;
    logic oe_q, ready_q, done_q, grant_q;
    logic locked_op;
    logic [2:0] step;
    logic go_write;
    logic ack_ok;
    logic ack_armed_q;

    // Bytes moved this cycle for a given acknowledge code and offset
    function automatic logic [2:0] port_bytes(input logic [1:0] ack,
                                             input logic [1:0] off,
                                             input logic [2:0] want);
        logic [2:0] cap;
        cap = 3'h1;
        case (ack)
            ABW_ACK_B32: cap = 3'h4 - {1'b0, off};
            ABW_ACK_B16: cap = 3'h2 - {2'h0, off[0]};
            default: cap = 3'h1;
        endcase
        port_bytes = (cap < want) ? cap : want;
    endfunction

    // Read data stand-in: this model has no data input, so the byte count is returned in the low bits
    function automatic logic [31:0] o_rdata_in(input logic [2:0] n);
        o_rdata_in = {29'h0, n};
    endfunction

    assign locked_op = (req_q.op != ABW_OP_WRITE); // R17
    assign step = port_bytes(ack_s_q, addr_q[1:0], left_q); // R24
    // Test-and-set always writes; compares write only on a match
    assign go_write = locked_op && !write_ph_q
        && (req_q.op == ABW_OP_TAS || i_cmp_ok); // R17
    assign ack_ok = ack_armed_q && (ack_s_q != ABW_ACK_NONE); // R7

    // A released acknowledge takes two edges to leave the synchroniser, so
    // the next cycle must not end on that leftover
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ack_armed_q <= 1'b0;
        end else if (state_q == ABW_S45) begin
            ack_armed_q <= 1'b0;
        end else if (ack_s_q == ABW_ACK_NONE) begin
            ack_armed_q <= 1'b1; // R8
        end
    end

    // Acknowledge and bus request come off pins: two flops first
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ack_m_q <= ABW_ACK_NONE;
            ack_s_q <= ABW_ACK_NONE;
            br_m_q <= 1'b0;
            br_s_q <= 1'b0;
        end else begin
            ack_m_q <= ~i_ack_size_lines_n;
            ack_s_q <= ack_m_q;
            br_m_q <= ~i_bus_request_in_n;
            br_s_q <= br_m_q;
        end
    end

    // Sequencer
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_q <= ABW_IDLE;
            req_q <= '0;
            left_q <= ABW_NB_RESET;
            write_ph_q <= 1'b0;
            gap_q <= 2'h0;
            ready_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            ready_q <= 1'b0;
            case (state_q)
                ABW_IDLE: begin
                    ready_q <= 1'b1;
                    if (i_req_valid && ready_q) begin
                        ready_q <= 1'b0;
                        req_q <= i_req;
                        left_q <= i_req.nbytes;
                        write_ph_q <= (i_req.op == ABW_OP_WRITE);
                        state_q <= ABW_S01;
                    end
                end
                ABW_S01: state_q <= ABW_S23;
                ABW_S23, ABW_WAIT: begin
                    if (ack_ok) begin
                        state_q <= ABW_S45; // R7
                    end else begin
                        state_q <= ABW_WAIT; // R8
                    end
                end
                ABW_S45: begin
                    left_q <= left_q - step;
                    if (left_q > step) begin
                        state_q <= ABW_S01; // R24
                    end else if (go_write) begin
                        // Idle states before the write part of the lock
                        left_q <= req_q.nbytes;
                        write_ph_q <= 1'b1;
                        gap_q <= ABW_IDLE_HALVES;
                        state_q <= ABW_GAP; // R22
                    end else begin
                        done_q <= 1'b1;
                        state_q <= ABW_IDLE; // R17
                    end
                end
                ABW_GAP: begin
                    gap_q <= gap_q - 2'h1;
                    if (gap_q == 2'h1) begin
                        state_q <= ABW_S01;
                    end
                end
                default: state_q <= ABW_IDLE;
            endcase
        end
    end

    // Address, size, space and data; held through S5 and the gap
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            addr_q <= ABW_ADDR_RESET;
            space_q <= ABW_SPACE_RESET;
            size_q <= 2'h0;
            dout_q <= 32'h0;
            oe_q <= 1'b0; // R23
            rdata_q <= 32'h0;
        end else begin
            if (state_q == ABW_IDLE && i_req_valid && ready_q) begin
                addr_q <= i_req.addr; // R1 R18
                space_q <= i_req.space;
                size_q <= i_req.nbytes[1:0];
                dout_q <= i_req.wdata;
            end
            if (state_q == ABW_S45 && left_q > step) begin
                addr_q <= addr_q + {29'h0, step};
                size_q <= left_q[1:0] - step[1:0];
                dout_q <= dout_q << {step, 3'h0};
            end
            if (state_q == ABW_S45 && !write_ph_q) begin
                rdata_q <= (rdata_q << {step, 3'h0}) | o_rdata_in(step);
            end
            if (state_q == ABW_GAP && gap_q == 2'h1) begin
                addr_q <= req_q.addr;
                size_q <= req_q.nbytes[1:0];
            end
            if (state_q == ABW_S01 && write_ph_q) begin
                oe_q <= 1'b1; // R5 R22
            end else if (state_q == ABW_IDLE || !write_ph_q) begin
                oe_q <= 1'b0;
            end
        end
    end

    // Strobes: one field per flop, steered by the state being entered
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ctl_q <= '0; // R23
            ctl_q.rd_wr_n <= 1'b1;
        end else begin
            case (state_q)
                ABW_IDLE: begin
                    ctl_q <= '0;
                    ctl_q.rd_wr_n <= 1'b1;
                    if (i_req_valid && ready_q) begin
                        ctl_q.cycle_start_strobe <= 1'b1; // R2 R19
                        ctl_q.operand_start_strobe <= 1'b1;
                        ctl_q.rd_wr_n <= (i_req.op != ABW_OP_WRITE); // R1
                        ctl_q.locked_sequence_flag <=
                            (i_req.op != ABW_OP_WRITE); // R18
                    end
                end
                ABW_S01: begin
                    ctl_q.cycle_start_strobe <= 1'b0; // R4 R20
                    ctl_q.operand_start_strobe <= 1'b0;
                    ctl_q.address_strobe <= 1'b1; // R3
                    ctl_q.data_strobe <= 1'b1; // R6 R20
                    ctl_q.data_buffer_enable <= 1'b1; // R4 R21
                end
                ABW_S23, ABW_WAIT: begin
                    // S4 issues nothing new; strobes fall with S5
                    if (ack_ok) begin
                        ctl_q.address_strobe <= 1'b0; // R12 R13
                        ctl_q.data_strobe <= 1'b0;
                        ctl_q.data_buffer_enable <= write_ph_q;
                    end
                end
                ABW_S45: begin
                    ctl_q.data_buffer_enable <= 1'b0;
                    if (left_q > step) begin
                        ctl_q.cycle_start_strobe <= 1'b1;
                    end else if (!go_write) begin
                        ctl_q.locked_sequence_flag <= 1'b0; // R15
                    end
                end
                ABW_GAP: begin
                    if (gap_q == 2'h1) begin
                        ctl_q.rd_wr_n <= 1'b0; // R22
                        ctl_q.cycle_start_strobe <= 1'b1;
                        ctl_q.operand_start_strobe <= 1'b1;
                    end
                end
                default: ctl_q <= '0;
            endcase
        end
    end

    // Grant withheld for the whole locked sequence
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            grant_q <= 1'b0;
        end else begin
            grant_q <= br_s_q && state_q == ABW_IDLE
                && !ctl_q.locked_sequence_flag && !i_req_valid; // R16
        end
    end

    assign o_ctl = ctl_q;
    assign o_addr = addr_q;
    assign o_space = space_q;
    assign o_transfer_size = size_q;
    assign o_data_out = dout_q;
    assign o_data_oe = oe_q;
    assign o_req_ready = ready_q;
    assign o_done = done_q;
    assign o_rdata = rdata_q;
    assign o_bus_grant_out = grant_q;

    lock_hold_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (state_q == ABW_GAP) |-> ctl_q.locked_sequence_flag) // R15
        else $error("lock flag dropped inside locked sequence");
    no_grant_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        ctl_q.locked_sequence_flag |-> !grant_q) // R16
        else $error("grant during locked sequence");
    s1_strobe_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (state_q == ABW_S01) |=> ctl_q.address_strobe
            && !ctl_q.cycle_start_strobe) // R3
        else $error("address strobe missing in S1");
    wait_hold_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (state_q == ABW_WAIT && ack_s_q == ABW_ACK_NONE)
            |=> state_q == ABW_WAIT && ctl_q.address_strobe) // R8
        else $error("wait state not held");
    term_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (state_q inside {ABW_S23, ABW_WAIT} && ack_ok)
            |=> state_q == ABW_S45 && !ctl_q.data_strobe) // R7
        else $error("cycle not ended after acknowledge");
    stale_ack_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (state_q == ABW_S23 && !ack_armed_q) |=> state_q == ABW_WAIT) // R8
        else $error("leftover acknowledge ended a cycle");
    sequence lock_turn_s;
        state_q == ABW_GAP && gap_q == 2'h1;
    endsequence
    sequence write_start_s;
        !ctl_q.rd_wr_n && ctl_q.operand_start_strobe
            && ctl_q.locked_sequence_flag;
    endsequence
    turn_write_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        lock_turn_s |=> write_start_s) // R22
        else $error("write portion not opened after lock gap");
    rd_in_gap_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (state_q == ABW_GAP) |-> ctl_q.rd_wr_n && !oe_q) // R22
        else $error("bus turned before write portion");
    wr_level_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (state_q == ABW_S23 && write_ph_q) |-> !ctl_q.rd_wr_n) // R1
        else $error("write cycle not at write level");
    s5_addr_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (state_q == ABW_S45) |-> $stable(addr_q)) // R13
        else $error("address moved in S5");
endmodule
`default_nettype wire

// [verif/abw_slave_model.sv]
`timescale 1ns/10ps
`default_nettype none
module abw_slave_model (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire abw_pkg::abw_ctl_s i_ctl,
    input wire logic [31:0] i_data,
    input wire logic i_oe,
    input wire logic [7:0] i_wait,
    input wire logic [1:0] i_width_n,
    output logic [1:0] o_ack_n,
    output logic [31:0] o_cap
);
    import abw_pkg::*;
    logic [7:0] cnt_q;
    logic [31:0] bus;
    // An undriven bus shows no stale data
    assign bus = i_oe ? i_data : ~i_data;
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_ack_n <= 2'h3;
            cnt_q <= 8'h0;
            o_cap <= 32'h0;
        end else if (!i_ctl.address_strobe || !i_ctl.data_strobe) begin
            // Early release, else the next cycle sees a stale ack
            o_ack_n <= 2'h3;
            cnt_q <= 8'h0;
        end else if (o_ack_n == 2'h3) begin
            if (cnt_q >= i_wait) begin
                o_ack_n <= i_width_n;
                if (!i_ctl.rd_wr_n) begin
                    o_cap <= (i_width_n == 2'h2) ?
                        {o_cap[23:0], bus[31:24]} : bus;
                end
            end else begin
                cnt_q <= cnt_q + 8'h1;
            end
        end
    end
endmodule
`default_nettype wire

// [verif/tb.sv]
`timescale 1ns/10ps
`default_nettype none
module tb;
    import abw_pkg::*;
    logic i_clk, i_arst_n, i_req_valid, i_cmp_ok, i_bus_request_in_n;
    abw_req_s i_req;
    abw_ctl_s o_ctl;
    logic o_req_ready, o_done, o_data_oe, o_bus_grant_out;
    logic [31:0] o_rdata, o_addr, o_data_out, cap, f_addr;
    logic [2:0] o_space;
    logic [1:0] o_transfer_size, ack_n, width_n;
    logic [7:0] wait_n, f_vec;
    int n_mismatch, n_compared, n_st, n_wr, n_gap, n_gnt, n_chg;
    int run_as, max_as;

    abw_bus_master dut (.i_clk(i_clk), .i_arst_n(i_arst_n),
        .i_req_valid(i_req_valid), .i_req(i_req), .i_cmp_ok(i_cmp_ok),
        .i_ack_size_lines_n(ack_n), .i_bus_request_in_n(i_bus_request_in_n),
        .o_req_ready(o_req_ready), .o_done(o_done), .o_rdata(o_rdata),
        .o_ctl(o_ctl), .o_addr(o_addr), .o_space(o_space),
        .o_transfer_size(o_transfer_size), .o_data_out(o_data_out),
        .o_data_oe(o_data_oe), .o_bus_grant_out(o_bus_grant_out));
    abw_slave_model slv (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_ctl(o_ctl),
        .i_data(o_data_out), .i_oe(o_data_oe), .i_wait(wait_n),
        .i_width_n(width_n), .o_ack_n(ack_n), .o_cap(cap));

    initial begin
        i_clk = 1'b0;
        forever #2 i_clk = ~i_clk;
    end

    task automatic conclude;
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // One operation, watched cycle by cycle until done
    task automatic run(input abw_op_e op, input logic [2:0] nb,
                       input logic [31:0] wd, input logic breq);
        int k;
        logic [31:0] pa;
        {n_st, n_wr, n_gap, n_gnt, n_chg, run_as, max_as} = '0;
        k = 0;
        while (o_req_ready !== 1'b1 && k < 50) begin
            @(negedge i_clk);
            k++;
        end
        if (k >= 50) begin
            n_mismatch++;
            $display("mismatch at %0t: device never ready", $time);
            conclude();
        end
        i_req <= '{op, 32'h100, 3'h5, nb, wd};
        i_req_valid <= 1'b1;
        @(negedge i_clk);
        i_req_valid <= 1'b0;
        i_bus_request_in_n <= breq;
        k = 0;
        while (o_done !== 1'b1 && k < 400) begin
            if (o_ctl.cycle_start_strobe === 1'b1) begin
                if (n_st == 0) begin
                    f_vec = {o_ctl.rd_wr_n, o_ctl.operand_start_strobe,
                        o_ctl.address_strobe, o_transfer_size, o_space};
                    f_addr = o_addr;
                end
                n_st++;
            end
            if (o_ctl.address_strobe === 1'b1) begin
                run_as++;
                if (run_as > 1 && o_addr !== pa)
                    n_chg++;
                if (o_ctl.rd_wr_n === 1'b0)
                    n_wr++;
                if ({o_ctl.data_strobe, o_ctl.data_buffer_enable} !== 2'h3)
                    n_gap++;
                if (op != ABW_OP_WRITE && o_ctl.locked_sequence_flag !== 1'b1)
                    n_gap++;
            end else begin
                run_as = 0;
            end
            max_as = (run_as > max_as) ? run_as : max_as;
            if (o_bus_grant_out !== 1'b0)
                n_gnt++;
            pa = o_addr;
            @(negedge i_clk);
            k++;
        end
        i_bus_request_in_n <= 1'b1;
        if (k >= 400) begin
            n_mismatch++;
            $display("mismatch at %0t: operation never finished", $time);
            conclude();
        end
    endtask

    task automatic t_idle;
        chk({o_ctl.cycle_start_strobe, o_ctl.operand_start_strobe,
            o_ctl.address_strobe, o_ctl.data_strobe, o_data_oe,
            o_ctl.data_buffer_enable, o_ctl.locked_sequence_flag}, 0);
    endtask

    task automatic t_write;
        int fast;
        width_n = 2'h0;
        wait_n = 8'h0;
        run(ABW_OP_WRITE, 3'h4, 32'ha5c3_1e77, 1'b1);
        fast = max_as;
        chk(f_vec, 32'h45);
        chk(f_addr, 32'h100);
        chk(n_st, 1);
        chk(cap, 32'ha5c3_1e77);
        chk(n_chg, 0);
        chk(n_gap, 0);
        wait_n = 8'h6;
        run(ABW_OP_WRITE, 3'h2, 32'h0000_3c5a, 1'b1);
        chk(max_as - fast, 6);
        chk(f_vec[4:3], 2'h2);
    endtask

    task automatic t_port8;
        width_n = 2'h2;
        wait_n = 8'h1;
        run(ABW_OP_WRITE, 3'h4, 32'h1234_5678, 1'b1);
        chk(n_st, 4);
        chk(cap, 32'h1234_5678);
        chk(n_chg, 0);
    endtask

    // Bus request held low across every locked operation
    task automatic t_lock;
        abw_op_e ops[4] = '{ABW_OP_TAS, ABW_OP_CAS, ABW_OP_DOUBLE_COMPARE_SWAP_OP, ABW_OP_CAS};
        width_n = 2'h0;
        wait_n = 8'h2;
        for (int i = 0; i < 4; i++) begin
            i_cmp_ok = (i == 3);
            run(ops[i], 3'h4, 32'hffff_0000, 1'b0);
            chk(f_vec[7:5], 3'h6);
            chk(n_gap, 0);
            chk(n_gnt, 0);
            if (i == 1 || i == 2)
                chk(n_wr, 0);
            else
                chk(n_wr > 0, 1);
        end
    endtask

    task automatic t_grant;
        int k;
        i_bus_request_in_n = 1'b0;
        k = 0;
        while (o_bus_grant_out !== 1'b1 && k < 20) begin
            @(negedge i_clk);
            k++;
        end
        chk(o_bus_grant_out, 1);
        i_bus_request_in_n = 1'b1;
        repeat (4) @(negedge i_clk);
    endtask

    initial begin
        i_arst_n = 1'b0;
        i_req_valid = 1'b0;
        i_req = '0;
        i_cmp_ok = 1'b0;
        i_bus_request_in_n = 1'b1;
        width_n = 2'h0;
        wait_n = 8'h0;
        repeat (16) @(negedge i_clk);
        t_idle();
        i_arst_n = 1'b1;
        repeat (2) @(negedge i_clk);
        t_idle();
        t_write();
        t_port8();
        t_lock();
        t_grant();
        conclude();
    end
endmodule
`default_nettype wire
